/* File: logic/dcrf_pkg.sv */
// Shared constants, register map and filter tables for the converter rate filters
package dcrf_pkg;
   // Datapath widths
   localparam int SW = 12;
   localparam int OW = 6;
   localparam int AC = 36;
   localparam int SMAX = (1 <<< (SW - 1)) - 1;
   localparam int SMIN = -(1 <<< (SW - 1));
   typedef logic signed [SW-1:0] dcrf_smp_t;

   // Device register map
   localparam logic [7:0] A_CHSEL = 8'h05;
   localparam logic [7:0] A_OFFS = 8'h10;
   localparam logic [7:0] A_UPD = 8'hff;
   localparam logic [7:0] A_CFG = 8'h20;
   localparam logic [7:0] A_STAT = 8'h21;
   localparam logic [7:0] CH_NONE = 8'h00;
   localparam logic [7:0] CH_I = 8'h01;
   localparam logic [7:0] CH_Q = 8'h02;
   localparam logic [7:0] UPD_CLR = 8'h00;
   localparam logic [7:0] UPD_GO = 8'h01;
   localparam int CFG_DEC = 0;
   localparam int CFG_RAT = 1;
   localparam int CFG_PORT = 3;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [5:0] OFFS_RST = 6'h00;

   // Host register map
   localparam logic [7:0] H_CTRL = 8'h00;
   localparam logic [7:0] H_IOFF = 8'h01;
   localparam logic [7:0] H_QOFF = 8'h02;
   localparam logic [7:0] H_CFG = 8'h03;
   localparam logic [7:0] H_STAT = 8'h04;
   localparam logic [7:0] H_DRA = 8'h05;
   localparam logic [7:0] H_DRD = 8'h06;
   localparam int NSTEP = 8;

   // Transmit buffer
   localparam int FIFO_DEPTH = 8;

   // Filter tables: unique taps from H(1) up to the centre, zero padded
   localparam int NU = 27;
   localparam int NTAPS [3] = '{43, 19, 53};
   localparam int SH [3] = '{14, 13, 14};
   localparam int SH_RX = 15;
   localparam int COEF [3][27] = '{
      '{12, 0, -32, 0, 72, 0, -140, 0, 252, 0, -422, 0, 682, 0, -1086, 0, 1778, 0, -3284, 0,
        10364, 16384, 0, 0, 0, 0, 0},
      '{26, 0, -138, 0, 466, 0, -1314, 0, 5058, 8191, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
        0, 0, 0, 0, 0, 0, 0},
      '{-2, -2, 8, -4, -21, 10, 44, -29, -79, 66, 123, -127, -183, 232, 251, -394, -326, 642,
        401, -1034, -469, 1704, 523, -3160, -560, 9996, 16383}};
endpackage

/* File: logic/dcrf_if.sv */
// Link between the converter end and the baseband end
`timescale 1ns/1ps
interface dcrf_if;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;
   logic rx_valid;
   dcrf_pkg::dcrf_smp_t rx_i;
   dcrf_pkg::dcrf_smp_t rx_q;
   dcrf_pkg::dcrf_smp_t tx_data0;
   dcrf_pkg::dcrf_smp_t tx_data1;
   logic tx_iq;
   logic tx_valid;
   logic tx_ready;
   modport dev(input reg_addr, reg_wdata, reg_wr, reg_rd, tx_data0, tx_data1, tx_iq, tx_valid,
               output reg_rdata, rx_valid, rx_i, rx_q, tx_ready);
   modport host(output reg_addr, reg_wdata, reg_wr, reg_rd, tx_data0, tx_data1, tx_iq, tx_valid,
                input reg_rdata, rx_valid, rx_i, rx_q, tx_ready);
endinterface

/* File: logic/dcrf_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dcrf_fifo #(
   parameter int W = 2 * dcrf_pkg::SW,
   parameter int D = dcrf_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Fill side
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready,
   // Occupancy
   output logic [$clog2(D):0] o_level
);
   localparam int PW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   wire push = i_valid && o_ready;
   wire pop = o_valid && i_ready;

   // Depth must be a power of two: pointers wrap naturally
   assign o_ready = cnt_q != (PW + 1)'(D);
   assign o_valid = cnt_q != '0;
   assign o_data = mem[rp_q];
   assign o_level = cnt_q;

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_q + PW'(push);
         rp_q <= rp_q + PW'(pop);
         cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wp_q] <= i_data;
      end
   end
endmodule

/* File: logic/dcrf_device.sv */
// Converter end: receive offset and decimator, transmit assembler and interpolators
`timescale 1ns/1ps
module dcrf_device (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Receive converter samples
   input wire logic i_adc_valid,
   input wire dcrf_pkg::dcrf_smp_t i_adc_i,
   input wire dcrf_pkg::dcrf_smp_t i_adc_q,
   // Transmit converter samples
   output logic o_dac_valid,
   output dcrf_pkg::dcrf_smp_t o_dac_i,
   output dcrf_pkg::dcrf_smp_t o_dac_q,
   // Link to baseband
   dcrf_if.dev lnk
);
   ////////////////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers

   function automatic dcrf_pkg::dcrf_smp_t sat_add(input dcrf_pkg::dcrf_smp_t x, input logic [5:0] o);
      logic signed [dcrf_pkg::SW:0] s;
      s = (dcrf_pkg::SW + 1)'(x) + (dcrf_pkg::SW + 1)'($signed(o));
      if (s > (dcrf_pkg::SW + 1)'(dcrf_pkg::SMAX)) begin
         s = (dcrf_pkg::SW + 1)'(dcrf_pkg::SMAX);
      end else if (s < (dcrf_pkg::SW + 1)'(dcrf_pkg::SMIN)) begin
         s = (dcrf_pkg::SW + 1)'(dcrf_pkg::SMIN);
      end
      return s[dcrf_pkg::SW-1:0];
   endfunction

   function automatic logic signed [dcrf_pkg::AC-1:0] fir(input dcrf_pkg::dcrf_smp_t ln [53], input int s);
      logic signed [dcrf_pkg::AC-1:0] a;
      int n;
      int m;
      a = '0;
      n = dcrf_pkg::NTAPS[s];
      m = (n - 1) / 2;
      // Folded symmetric form halves the multipliers
      for (int k = 0; k < dcrf_pkg::NU; k++) begin
         if (k < m) begin
            a = a + dcrf_pkg::AC'(dcrf_pkg::COEF[s][k]) * (dcrf_pkg::AC'(ln[k]) + dcrf_pkg::AC'(ln[n-1-k]));
         end else if (k == m) begin
            a = a + dcrf_pkg::AC'(dcrf_pkg::COEF[s][k]) * dcrf_pkg::AC'(ln[k]);
         end
      end
      return a;
   endfunction

   function automatic dcrf_pkg::dcrf_smp_t rnd_sat(input logic signed [dcrf_pkg::AC-1:0] acc, input int sh);
      logic signed [dcrf_pkg::AC-1:0] r;
      r = (acc + dcrf_pkg::AC'(1 <<< (sh - 1))) >>> sh;
      if (r > dcrf_pkg::AC'(dcrf_pkg::SMAX)) begin
         r = dcrf_pkg::AC'(dcrf_pkg::SMAX);
      end else if (r < dcrf_pkg::AC'(dcrf_pkg::SMIN)) begin
         r = dcrf_pkg::AC'(dcrf_pkg::SMIN);
      end
      return r[dcrf_pkg::SW-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register port

   logic [7:0] chsel_q;
   logic [5:0] soff_q [2];
   logic [5:0] aoff_q [2];
   logic upd_q;
   logic [7:0] scfg_q;
   logic [7:0] acfg_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_d;
   logic [$clog2(dcrf_pkg::FIFO_DEPTH):0] level;

   wire wr_sel = lnk.reg_wr && lnk.reg_addr == dcrf_pkg::A_CHSEL;
   wire wr_off = lnk.reg_wr && lnk.reg_addr == dcrf_pkg::A_OFFS;
   wire wr_upd = lnk.reg_wr && lnk.reg_addr == dcrf_pkg::A_UPD;
   wire wr_cfg = lnk.reg_wr && lnk.reg_addr == dcrf_pkg::A_CFG;
   wire sel_i = chsel_q == dcrf_pkg::CH_I;
   wire sel_q = chsel_q == dcrf_pkg::CH_Q;
   wire upd_rise = wr_upd && lnk.reg_wdata[0] && !upd_q;
   wire dec_en = acfg_q[dcrf_pkg::CFG_DEC];
   wire [1:0] ratio = acfg_q[dcrf_pkg::CFG_RAT+:2];
   wire port_b = acfg_q[dcrf_pkg::CFG_PORT];

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         chsel_q <= dcrf_pkg::CH_NONE;
         soff_q <= '{default: dcrf_pkg::OFFS_RST};
         aoff_q <= '{default: dcrf_pkg::OFFS_RST};
         upd_q <= 1'b0;
         scfg_q <= dcrf_pkg::CFG_RST;
         acfg_q <= dcrf_pkg::CFG_RST;
      end else begin
         if (wr_sel) begin
            chsel_q <= lnk.reg_wdata;
         end
         // With no channel selected the offset write is dropped
         if (wr_off && sel_i) begin
            soff_q[0] <= lnk.reg_wdata[5:0];
         end
         if (wr_off && sel_q) begin
            soff_q[1] <= lnk.reg_wdata[5:0];
         end
         if (wr_upd) begin
            upd_q <= lnk.reg_wdata[0];
         end
         if (wr_cfg) begin
            scfg_q <= lnk.reg_wdata;
         end
         if (upd_rise) begin
            aoff_q <= soff_q;
            acfg_q <= scfg_q;
         end
      end
   end

   always_comb begin
      case (lnk.reg_addr)
         dcrf_pkg::A_CHSEL: rd_d = chsel_q;
         dcrf_pkg::A_OFFS: rd_d = sel_i ? 8'($signed(soff_q[0])) : sel_q ? 8'($signed(soff_q[1])) : 8'h00;
         dcrf_pkg::A_UPD: rd_d = {7'h00, upd_q};
         dcrf_pkg::A_CFG: rd_d = scfg_q;
         dcrf_pkg::A_STAT: rd_d = 8'(level);
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= lnk.reg_rd ? rd_d : 8'h00;
      end
   end
   assign lnk.reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Receive path

   dcrf_pkg::dcrf_smp_t adj [2];
   dcrf_pkg::dcrf_smp_t rln_q [2][53];
   dcrf_pkg::dcrf_smp_t rln_d [2][53];
   dcrf_pkg::dcrf_smp_t rx_q [2];
   logic rph_q;
   logic rxv_q;

   assign adj[0] = sat_add(i_adc_i, aoff_q[0]);
   assign adj[1] = sat_add(i_adc_q, aoff_q[1]);

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         rln_d[c][0] = i_adc_valid ? adj[c] : rln_q[c][0];
         for (int k = 1; k < 53; k++) begin
            rln_d[c][k] = i_adc_valid ? rln_q[c][k-1] : rln_q[c][k];
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         rln_q <= '{default: '{default: '0}};
         rx_q <= '{default: '0};
         rph_q <= 1'b0;
         rxv_q <= 1'b0;
      end else begin
         rln_q <= rln_d;
         rph_q <= dec_en && (rph_q ^ i_adc_valid);
         rxv_q <= i_adc_valid && (!dec_en || rph_q);
         for (int c = 0; c < 2; c++) begin
            if (i_adc_valid) begin
               rx_q[c] <= dec_en ? rnd_sat(fir(rln_d[c], 0), dcrf_pkg::SH_RX) : adj[c];
            end
         end
      end
   end
   assign lnk.rx_valid = rxv_q;
   assign lnk.rx_i = rx_q[0];
   assign lnk.rx_q = rx_q[1];

   ////////////////////////////////////////////////////////////////////////////////////////
   // Transmit assembler and buffer

   dcrf_pkg::dcrf_smp_t ihold_q;
   logic fv;
   logic [2*dcrf_pkg::SW-1:0] fd;
   logic v [4];
   logic rdy [4];
   dcrf_pkg::dcrf_smp_t d [4][2];

   wire tx_take = lnk.tx_valid && lnk.tx_ready;
   wire dcrf_pkg::dcrf_smp_t word = port_b ? lnk.tx_data1 : lnk.tx_data0;

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ihold_q <= '0;
      end else if (tx_take && lnk.tx_iq) begin
         ihold_q <= word;
      end
   end

   dcrf_fifo #(.W(2 * dcrf_pkg::SW), .D(dcrf_pkg::FIFO_DEPTH)) u_fifo (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_valid(tx_take && !lnk.tx_iq),
      .i_data({ihold_q, word}),
      .o_ready(lnk.tx_ready),
      .o_valid(fv),
      .o_data(fd),
      .i_ready(rdy[0]),
      .o_level(level)
   );

   assign v[0] = fv;
   assign d[0][0] = fd[2*dcrf_pkg::SW-1:dcrf_pkg::SW];
   assign d[0][1] = fd[dcrf_pkg::SW-1:0];
   assign rdy[3] = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Interpolation chain, one shared control per stage, data per channel

   for (genvar s = 0; s < 3; s++) begin : g_st
      logic ph_q;
      logic ov_q;
      dcrf_pkg::dcrf_smp_t od_q [2];
      dcrf_pkg::dcrf_smp_t ln_q [2][53];
      dcrf_pkg::dcrf_smp_t ln_d [2][53];
      wire en = ratio > 2'(s);
      wire adv = en && (!ov_q || rdy[s+1]) && (ph_q || v[s]);
      assign rdy[s] = en ? (!ov_q || rdy[s+1]) && !ph_q : rdy[s+1];
      assign v[s+1] = en ? ov_q : v[s];
      for (genvar c = 0; c < 2; c++) begin : g_ch
         assign d[s+1][c] = en ? od_q[c] : d[s][c];
      end

      // Odd phase stuffs a zero, so each input yields two outputs
      always_comb begin
         for (int c = 0; c < 2; c++) begin
            ln_d[c][0] = adv ? (ph_q ? '0 : d[s][c]) : ln_q[c][0];
            for (int k = 1; k < 53; k++) begin
               ln_d[c][k] = adv ? ln_q[c][k-1] : ln_q[c][k];
            end
         end
      end

      always_ff @(posedge i_mclk or posedge i_reset) begin
         if (i_reset) begin
            ph_q <= 1'b0;
            ov_q <= 1'b0;
            od_q <= '{default: '0};
            ln_q <= '{default: '{default: '0}};
         end else begin
            ph_q <= ph_q ^ adv;
            ov_q <= adv || (ov_q && !rdy[s+1]);
            ln_q <= ln_d;
            for (int c = 0; c < 2; c++) begin
               if (adv) begin
                  od_q[c] <= rnd_sat(fir(ln_d[c], s), dcrf_pkg::SH[s]);
               end
            end
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_dac_valid <= 1'b0;
         o_dac_i <= '0;
         o_dac_q <= '0;
      end else begin
         o_dac_valid <= v[3];
         if (v[3]) begin
            o_dac_i <= d[3][0];
            o_dac_q <= d[3][1];
         end
      end
   end
endmodule

/* File: logic/dcrf_host.sv */
// Baseband end: offset programming sequencer, transmit interleaver, receive capture
`timescale 1ns/1ps
module dcrf_host (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Transmit samples
   input wire logic i_tx_valid,
   input wire dcrf_pkg::dcrf_smp_t i_tx_i,
   input wire dcrf_pkg::dcrf_smp_t i_tx_q,
   output logic o_tx_ready,
   // Receive samples
   output logic o_rx_valid,
   output dcrf_pkg::dcrf_smp_t o_rx_i,
   output dcrf_pkg::dcrf_smp_t o_rx_q,
   // Link to converter
   dcrf_if.host lnk
);
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_RUN = 2'b01} dcrf_hst_t;

   // Program sequence: both offsets, back to normal addressing, config, then 0-to-1 update
   function automatic logic [15:0] step(input logic [2:0] n, input logic [5:0] io,
                                        input logic [5:0] qo, input logic [7:0] cf);
      case (n)
         3'h0: step = {dcrf_pkg::A_CHSEL, dcrf_pkg::CH_I};
         3'h1: step = {dcrf_pkg::A_OFFS, 8'($signed(io))};
         3'h2: step = {dcrf_pkg::A_CHSEL, dcrf_pkg::CH_Q};
         3'h3: step = {dcrf_pkg::A_OFFS, 8'($signed(qo))};
         3'h4: step = {dcrf_pkg::A_CHSEL, dcrf_pkg::CH_NONE};
         3'h5: step = {dcrf_pkg::A_CFG, cf};
         3'h6: step = {dcrf_pkg::A_UPD, dcrf_pkg::UPD_CLR};
         default: step = {dcrf_pkg::A_UPD, dcrf_pkg::UPD_GO};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // User registers and sequencer

   dcrf_hst_t st_q;
   logic [2:0] step_q;
   logic [5:0] ioff_q;
   logic [5:0] qoff_q;
   logic [7:0] cfg_q;
   logic [7:0] dra_q;
   logic [7:0] drd_q;
   logic [7:0] rdata_q;
   logic [7:0] ra_q;
   logic [7:0] rw_q;
   logic rwr_q;
   logic rrd_q;
   logic rpend_q;
   logic [7:0] rd_d;

   wire run = st_q == S_RUN;
   wire go = i_wr && i_addr == dcrf_pkg::H_CTRL && i_wdata[0] && !run;
   wire dra_wr = i_wr && i_addr == dcrf_pkg::H_DRA;
   wire [15:0] cur = step(step_q, ioff_q, qoff_q, cfg_q);

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         st_q <= S_IDLE;
         step_q <= 3'h0;
         ioff_q <= dcrf_pkg::OFFS_RST;
         qoff_q <= dcrf_pkg::OFFS_RST;
         cfg_q <= dcrf_pkg::CFG_RST;
         dra_q <= 8'h00;
         drd_q <= 8'h00;
         ra_q <= 8'h00;
         rw_q <= 8'h00;
         rwr_q <= 1'b0;
         rrd_q <= 1'b0;
         rpend_q <= 1'b0;
      end else begin
         if (i_wr && i_addr == dcrf_pkg::H_IOFF) ioff_q <= i_wdata[5:0];
         if (i_wr && i_addr == dcrf_pkg::H_QOFF) qoff_q <= i_wdata[5:0];
         if (i_wr && i_addr == dcrf_pkg::H_CFG) cfg_q <= i_wdata;
         if (dra_wr) dra_q <= i_wdata;
         case (st_q)
            S_IDLE: begin
               step_q <= 3'h0;
               if (go) st_q <= S_RUN;
            end
            S_RUN: begin
               step_q <= step_q + 3'h1;
               if (step_q == 3'(dcrf_pkg::NSTEP - 1)) st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
         // Reads of the far end are refused while the sequence runs
         rwr_q <= run;
         rrd_q <= dra_wr && !run;
         if (run) begin
            ra_q <= cur[15:8];
            rw_q <= cur[7:0];
         end else if (dra_wr) begin
            ra_q <= i_wdata;
         end
         rpend_q <= rrd_q;
         if (rpend_q) drd_q <= lnk.reg_rdata;
      end
   end
   assign lnk.reg_addr = ra_q;
   assign lnk.reg_wdata = rw_q;
   assign lnk.reg_wr = rwr_q;
   assign lnk.reg_rd = rrd_q;

   always_comb begin
      case (i_addr)
         dcrf_pkg::H_IOFF: rd_d = {2'b00, ioff_q};
         dcrf_pkg::H_QOFF: rd_d = {2'b00, qoff_q};
         dcrf_pkg::H_CFG: rd_d = cfg_q;
         dcrf_pkg::H_STAT: rd_d = {6'h00, rpend_q || rrd_q, run || rwr_q};
         dcrf_pkg::H_DRA: rd_d = dra_q;
         dcrf_pkg::H_DRD: rd_d = drd_q;
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) rdata_q <= 8'h00;
      else rdata_q <= i_rd ? rd_d : 8'h00;
   end
   assign o_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Transmit interleaver: I word first, then Q

   dcrf_pkg::dcrf_smp_t tw_q;
   dcrf_pkg::dcrf_smp_t qh_q;
   logic tiq_q;
   logic tv_q;
   wire lacc = tv_q && lnk.tx_ready;
   wire utake = i_tx_valid && o_tx_ready;
   assign o_tx_ready = !tv_q || (lacc && !tiq_q);

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         tw_q <= '0;
         qh_q <= '0;
         tiq_q <= 1'b0;
         tv_q <= 1'b0;
      end else if (utake) begin
         tw_q <= i_tx_i;
         qh_q <= i_tx_q;
         tiq_q <= 1'b1;
         tv_q <= 1'b1;
      end else if (lacc && tiq_q) begin
         tw_q <= qh_q;
         tiq_q <= 1'b0;
      end else if (lacc) begin
         tv_q <= 1'b0;
      end
   end
   assign lnk.tx_data0 = cfg_q[dcrf_pkg::CFG_PORT] ? '0 : tw_q;
   assign lnk.tx_data1 = cfg_q[dcrf_pkg::CFG_PORT] ? tw_q : '0;
   assign lnk.tx_iq = tiq_q;
   assign lnk.tx_valid = tv_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Receive capture

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_rx_valid <= 1'b0;
         o_rx_i <= '0;
         o_rx_q <= '0;
      end else begin
         o_rx_valid <= lnk.rx_valid;
         if (lnk.rx_valid) begin
            o_rx_i <= lnk.rx_i;
            o_rx_q <= lnk.rx_q;
         end
      end
   end
endmodule

/* File: verification/dcrf_props.sv */
// Checker for the register and transmit traffic on the link
`timescale 1ns/1ps
module dcrf_props (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Register traffic
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   // Transmit traffic
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_iq,
   input wire dcrf_pkg::dcrf_smp_t tx_data0,
   input wire dcrf_pkg::dcrf_smp_t tx_data1
);
   logic [7:0] sel_q;
   logic [7:0] cfg_q;
   wire logic wr_sel = reg_wr && reg_addr == dcrf_pkg::A_CHSEL;
   wire logic wr_cfg = reg_wr && reg_addr == dcrf_pkg::A_CFG;
   wire logic wr_upd = reg_wr && reg_addr == dcrf_pkg::A_UPD;
   wire logic upd_clr = wr_upd && reg_wdata == dcrf_pkg::UPD_CLR;
   wire logic upd_go = wr_upd && reg_wdata == dcrf_pkg::UPD_GO;
   wire logic rd_unmap = reg_rd && !(reg_addr inside {dcrf_pkg::A_CHSEL, dcrf_pkg::A_OFFS, dcrf_pkg::A_UPD,
      dcrf_pkg::A_CFG, dcrf_pkg::A_STAT});
   ////////////////////////////////////////////////////////////
   // Shadow copies, so readback is judged against what was written
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         sel_q <= dcrf_pkg::CH_NONE;
         cfg_q <= dcrf_pkg::CFG_RST;
      end else begin
         if (wr_sel) sel_q <= reg_wdata;
         if (wr_cfg) cfg_q <= reg_wdata;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   AST_ONE_STROBE: assert property (!(reg_wr && reg_rd))
      else $error("both register strobes high");
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   AST_SEL_READ: assert property (reg_rd && reg_addr == dcrf_pkg::A_CHSEL |=> reg_rdata == $past(sel_q))
      else $error("select readback wrong");
   AST_CFG_READ: assert property (reg_rd && reg_addr == dcrf_pkg::A_CFG |=> reg_rdata == $past(cfg_q))
      else $error("config readback wrong");
   AST_OFFS_NONE: assert property (reg_rd && reg_addr == dcrf_pkg::A_OFFS && sel_q == 8'h00 |=> reg_rdata == 8'h00)
      else $error("offset read without channel");
   AST_UNMAP: assert property (rd_unmap |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_SEQ: assert property (wr_sel && reg_wdata == dcrf_pkg::CH_I |=> reg_wr && reg_addr == dcrf_pkg::A_OFFS
      ##1 wr_sel && reg_wdata == dcrf_pkg::CH_Q ##1 reg_wr && reg_addr == dcrf_pkg::A_OFFS
      ##1 wr_sel && reg_wdata == dcrf_pkg::CH_NONE ##1 wr_cfg ##1 upd_clr ##1 upd_go)
      else $error("offset programming order broken");
   AST_UPD_EDGE: assert property (upd_go |-> $past(upd_clr))
      else $error("update set without prior clear");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_iq) && $stable(tx_data0)
      && $stable(tx_data1))
      else $error("transmit word dropped while refused");
   AST_TX_ORDER: assert property (tx_valid && tx_ready && tx_iq |=> tx_valid && !tx_iq)
      else $error("I word not followed by Q word");
endmodule

/* File: verification/tb_dual_converter_rate_filters.sv */
// Testbench joining both ends of the converter rate filter link
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0d got %0d", n, e, g); end end
module tb_dual_converter_rate_filters;
   logic i_mclk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_adc_valid = 1'b0, i_tx_valid = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
   logic o_tx_ready, o_rx_valid, o_dac_valid, full = 1'b0;
   dcrf_pkg::dcrf_smp_t i_adc_i = '0, i_adc_q = '0, i_tx_i = '0, i_tx_q = '0, o_rx_i, o_rx_q, o_dac_i, o_dac_q;
   int fails = 0, checks = 0, ndac = 0, nrx = 0, cyc = 0;
   dcrf_if dcrf_if_i ();
   dcrf_device dcrf_device_i (.i_mclk, .i_reset, .i_adc_valid, .i_adc_i, .i_adc_q, .o_dac_valid, .o_dac_i,
      .o_dac_q, .lnk(dcrf_if_i.dev));
   dcrf_host dcrf_host_i (.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_valid, .i_tx_i,
      .i_tx_q, .o_tx_ready, .o_rx_valid, .o_rx_i, .o_rx_q, .lnk(dcrf_if_i.host));
   dcrf_props dcrf_props_i (.i_mclk, .i_reset, .reg_addr(dcrf_if_i.reg_addr), .reg_wdata(dcrf_if_i.reg_wdata),
      .reg_rdata(dcrf_if_i.reg_rdata), .reg_wr(dcrf_if_i.reg_wr), .reg_rd(dcrf_if_i.reg_rd),
      .tx_valid(dcrf_if_i.tx_valid), .tx_ready(dcrf_if_i.tx_ready), .tx_iq(dcrf_if_i.tx_iq),
      .tx_data0(dcrf_if_i.tx_data0), .tx_data1(dcrf_if_i.tx_data1));
   initial forever #5 i_mclk = ~i_mclk;
   // Run-away guard: the whole sequence needs a few thousand cycles
   always @(posedge i_mclk) begin
      cyc++;
      if (o_dac_valid === 1'b1) ndac++;
      if (o_rx_valid === 1'b1) nrx++;
      if (dcrf_if_i.tx_ready === 1'b0) full = 1'b1;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (fails == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 `CHK("rdata", e, o_rdata)
      @(posedge i_mclk);
   endtask
   task automatic devrd(input logic [7:0] a, input logic [7:0] e);
      wr(dcrf_pkg::H_DRA, a);
      repeat (3) @(posedge i_mclk);
      rd(dcrf_pkg::H_DRD, e);
   endtask
   // Sequence runs eight fixed link writes, so a fixed wait covers it
   task automatic prog(input logic [7:0] io, input logic [7:0] qo, input logic [7:0] cf);
      wr(dcrf_pkg::H_IOFF, io);
      wr(dcrf_pkg::H_QOFF, qo);
      wr(dcrf_pkg::H_CFG, cf);
      wr(dcrf_pkg::H_CTRL, 8'h01);
      repeat (12) @(posedge i_mclk);
      rd(dcrf_pkg::H_STAT, 8'h00);
   endtask
   task automatic adc(input int i, input int q, input int ei, input int eq);
      i_adc_valid <= 1'b1;
      i_adc_i <= 12'(i);
      i_adc_q <= 12'(q);
      @(posedge i_mclk);
      i_adc_valid <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 `CHK("rx_i", ei, o_rx_i)
      `CHK("rx_q", eq, o_rx_q)
      @(posedge i_mclk);
   endtask
   task automatic push(input int i, input int q);
      i_tx_valid <= 1'b1;
      i_tx_i <= 12'(i);
      i_tx_q <= 12'(q);
      @(posedge i_mclk);
      while (o_tx_ready !== 1'b1) @(posedge i_mclk);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(dcrf_pkg::H_CFG, 8'h00);
      devrd(dcrf_pkg::A_CHSEL, 8'h00);
      devrd(dcrf_pkg::A_STAT, 8'h00);
      devrd(8'h33, 8'h00);
   endtask
   task automatic t_offset();
      // Offsets staged in the host registers only, nothing sent over the link, no update yet
      wr(dcrf_pkg::H_IOFF, 8'h06);
      wr(dcrf_pkg::H_QOFF, 8'hfe);
      adc(100, 100, 100, 100);
      prog(8'h06, 8'hfe, 8'h00);
      adc(100, 100, 106, 98);
      adc(2045, -2047, 2047, -2048);
      devrd(dcrf_pkg::A_OFFS, 8'h00);
      devrd(dcrf_pkg::A_CFG, 8'h00);
   endtask
   // Long constant run so the 43-tap window is full of the DC level
   task automatic t_decim();
      prog(8'h00, 8'h00, 8'h01);
      nrx = 0;
      i_adc_i <= 12'sd1000;
      i_adc_q <= -12'sd1000;
      i_adc_valid <= 1'b1;
      repeat (60) @(posedge i_mclk);
      i_adc_valid <= 1'b0;
      repeat (10) @(posedge i_mclk);
      `CHK("rx count", 30, nrx)
      `CHK("rx dc i", 1000, o_rx_i)
      `CHK("rx dc q", -1000, o_rx_q)
   endtask
   // 1x also moves to port 1; 8x drains slowly, so the buffer fills
   task automatic t_tx();
      for (int r = 0; r < 4; r++) begin
         prog(8'h00, 8'h00, 8'(r * 2 + (r == 0 ? 8 : 0)));
         ndac = 0;
         for (int k = 0; k < 24; k++) push(1000, -1000);
         i_tx_valid <= 1'b0;
         repeat (300) @(posedge i_mclk);
         `CHK("dac count", 24 << r, ndac)
         // At 1x the input passes; at 2x and 4x the last output is a stuffed phase: centre tap alone, but at 8x the even taps pass 15800/16384 of DC
         `CHK("dac i", r == 3 ? 964 : 1000, o_dac_i)
         `CHK("dac q", r == 3 ? -964 : -1000, o_dac_q)
      end
      `CHK("buffer refused", 1'b1, full)
   endtask
   initial begin
      repeat (5) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      t_reset();
      t_offset();
      t_decim();
      t_tx();
      stop_test();
   end
endmodule
